/* src/float_unit_consts.vh */
// Constants for the float unit and integer compare datapath
`ifndef FLOAT_UNIT_CONSTS_VH
`define FLOAT_UNIT_CONSTS_VH
// Operation codes on the issue port
`define OP_INT_CMP 4'h0
`define OP_FADD 4'h1
`define OP_FRSUB 4'h2
`define OP_FMUL 4'h3
`define OP_FDIV 4'h4
`define OP_FCMP 4'h5
`define OP_FLT 4'h6
`define OP_FINT 4'h7
// Bit positions in the float status register, then its width
`define FLAG_IO 4
`define FLAG_DZ 3
`define FLAG_OF 2
`define FLAG_UF 1
`define FLAG_DO 0
`define FLAG_W 5
// Exception cause and default result
`define CAUSE_FP 5'h06
`define CAUSE_NONE 5'h00
`define DEFAULT_NAN 32'hFFC00000
// Register word indices on the bus
`define REG_FLOAT_STATUS 2'h0
`define REG_EXC_CAUSE 2'h1
`define REG_UNIT_INFO 2'h2
// Compare relation codes
`define REL_UN 3'h0
`define REL_LT 3'h1
`define REL_EQ 3'h2
`define REL_LE 3'h3
`define REL_GT 3'h4
`define REL_NE 3'h5
`define REL_GE 3'h6
// Exponent constants
`define EXP_BIAS 12'h07F
`define EXP_MAX 12'h0FF
`define DIV_BIAS 12'h07E
`define I2F_EXP 12'h09D
`define F2I_EXP_LIMIT 8'h9E
`define ALIGN_LIMIT 8'h2F
// Latencies in cycles per area setting 0, 1, 2
`define LAT_ARITH_0 5'h04
`define LAT_ARITH_1 5'h06
`define LAT_ARITH_2 5'h01
`define LAT_DIV_0 5'h1C
`define LAT_DIV_1 5'h1E
`define LAT_DIV_2 5'h18
`define LAT_CMP_0 5'h01
`define LAT_CMP_1 5'h03
`define LAT_FLT_0 5'h05
`define LAT_FLT_1 5'h07
`define LAT_FLT_2 5'h02
`define LAT_ONE 5'h01
`endif

/* src/float_classify.v */
// Classifier of one floating-point operand
`timescale 1ns/10ps
`default_nettype none
module float_classify #(
   parameter EXP_W = 8,   // Exponent width
   parameter FRAC_W = 23  // Fraction width
) (
   // Operand
   input wire [EXP_W+FRAC_W:0] value,
   // Classes
   output wire isZero,
   output wire isDenorm,
   output wire isInf,
   output wire isQuietNan,
   output wire isSigNan
);
   wire [EXP_W-1:0] expField; // Biased exponent
   wire [FRAC_W-1:0] fracField; // Fraction bits
   wire expZero; // Exponent all zero
   wire expOnes; // Exponent all one
   assign expField = value[EXP_W+FRAC_W-1:FRAC_W];
   assign fracField = value[FRAC_W-1:0];
   assign expZero = ~|expField;
   assign expOnes = &expField;
   // Class decode
   assign isZero = expZero & ~|fracField;
   assign isDenorm = expZero & |fracField;
   assign isInf = expOnes & ~|fracField;
   assign isQuietNan = expOnes & fracField[FRAC_W-1];
   assign isSigNan = expOnes & ~fracField[FRAC_W-1] & |fracField;
endmodule
`default_nettype wire

/* src/float_unit_and_int_compare.v */
// Float unit datapath with integer compare and status registers
//
// Summary of operation
// - Integer compare writes B minus A, one cycle
// - Result MSB becomes one when A exceeds B
// - Unsigned bit picks unsigned or signed compare
// - Float add writes A plus B
// - Reverse subtract gives B minus A
// - Multiply gives product; latencies 4, 6, 1
// - Divide gives B over A; 28, 30, 24
// - Denormal operand first: flag, cause, default NaN
// - Exception keeps destination, updates cause code
// - Add invalid on signalling NaN, opposite infinities
// - Subtract invalid on signalling NaN, like infinities
// - Multiply zero-infinity, divide 0/0, inf/inf invalid
// - Quiet NaN gives default NaN, no flag
// - Zero divisor, finite dividend: signed infinity, divide flag
// - Tiny results zero, huge results infinity, flagged
// - Compare relation chosen by three-bit selector
// - NaN compare rules for result and invalid
// - Compare denormal gives zero, not written; latency 1 or 3
// - Integer to float rounds; latency 5, 7, 2
// - Float to integer truncates, flags bad inputs
// - Compare and conversions depend on unit config
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "float_unit_consts.vh"
module float_unit_and_int_compare #(
   parameter AREA_OPT = 0,          // Area setting 0, 1 or 2
   parameter FLOAT_UNIT_CONFIG = 2  // 0 off, 1 basic, 2 extended
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Issue side
   input wire opStart,
   input wire [3:0] opCode,
   input wire [31:0] operandA,
   input wire [31:0] operandB,
   input wire [2:0] compareRelationSelect,
   input wire unsignedSel,
   output wire opReady,
   // Result side
   output wire resultValid,
   output wire [31:0] resultData,
   output wire resultWrite,
   output wire exceptionRaise,
   output wire [4:0] exceptionCauseCode,
   // Avalon-MM slave
   input wire [1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest
);
   // State codes
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   localparam [1:0] AREA_CODE = AREA_OPT[1:0];
   localparam [1:0] CONFIG_CODE = FLOAT_UNIT_CONFIG[1:0];
   localparam FPU_ON = (FLOAT_UNIT_CONFIG > 0);
   localparam FPU_EXT = (FLOAT_UNIT_CONFIG == 2);

   // Round and pack; returns {overflow, underflow, word}
   function [33:0] roundPack;
      input s;
      input [11:0] e;
      input [47:0] m;
      reg [47:0] mm;
      reg [11:0] ee;
      reg [24:0] r;
      reg [5:0] lz;
      reg found;
      reg up;
      integer i;
      begin
         mm = m;
         ee = e;
         lz = 6'h00;
         found = 1'b0;
         // Carry out of the top: shift right, keep sticky
         if (mm[47]) begin
            mm = {1'b0, m[47:1]} | {47'h0, m[0]};
            ee = ee + 12'h001;
         end else begin
            // Count leading zeros from bit 46 down
            for (i = 46; i >= 0; i = i - 1) begin
               if (!found) begin
                  if (mm[i]) found = 1'b1;
                  else lz = lz + 6'h01;
               end
            end
            mm = mm << lz;
            ee = ee - {6'h00, lz};
         end
         // Round to nearest even
         up = mm[22] & (mm[23] | (|mm[21:0]));
         r = {1'b0, mm[46:23]} + {24'h000000, up};
         if (r[24]) begin
            r = {1'b0, r[24:1]};
            ee = ee + 12'h001;
         end
         if (m == 48'h0) begin
            roundPack = {2'b00, s, 31'h0};
         end else if (ee[11] || ee == 12'h000) begin
            roundPack = {2'b01, s, 31'h0};
         end else if (ee >= `EXP_MAX) begin
            roundPack = {2'b10, s, 8'hFF, 23'h0};
         end else begin
            roundPack = {2'b00, s, ee[7:0], r[22:0]};
         end
      end
   endfunction

   // Finite sum of two normal or zero operands
   function [33:0] fpAdd;
      input [31:0] a;
      input [31:0] b;
      reg [31:0] x;
      reg [31:0] y;
      reg [47:0] mx;
      reg [47:0] my;
      reg [47:0] sm;
      reg [7:0] d;
      begin
         // Larger magnitude goes first
         if (b[30:0] > a[30:0]) begin
            x = b;
            y = a;
         end else begin
            x = a;
            y = b;
         end
         mx = {1'b0, |x[30:23], x[22:0], 23'h0};
         my = {1'b0, |y[30:23], y[22:0], 23'h0};
         d = x[30:23] - y[30:23];
         // Align smaller operand, fold lost bits into sticky
         if (d > `ALIGN_LIMIT) begin
            my = {47'h0, |my};
         end else begin
            my = (my >> d) | {47'h0, |(my & ~({48{1'b1}} << d))};
         end
         if (x[31] ^ y[31]) sm = mx - my;
         else sm = mx + my;
         if (sm == 48'h0) fpAdd = {2'b00, x[31] & y[31], 31'h0};
         else fpAdd = roundPack(x[31], {4'h0, x[30:23]}, sm);
      end
   endfunction

   // Finite product of two normal operands
   function [33:0] fpMul;
      input [31:0] a;
      input [31:0] b;
      reg [47:0] p;
      begin
         p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
         fpMul = roundPack(a[31] ^ b[31],
            {4'h0, a[30:23]} + {4'h0, b[30:23]} - `EXP_BIAS, p);
      end
   endfunction

   // Finite quotient b over a of two normal operands
   function [33:0] fpDiv;
      input [31:0] b;
      input [31:0] a;
      reg [70:0] num;
      reg [70:0] den;
      reg [70:0] q;
      reg [70:0] rem;
      begin
         num = {24'h0, 1'b1, b[22:0], 23'h0} << 24;
         den = {47'h0, 1'b1, a[22:0]};
         q = num / den;
         rem = num - q * den;
         fpDiv = roundPack(a[31] ^ b[31],
            {4'h0, b[30:23]} - {4'h0, a[30:23]} + `DIV_BIAS,
            q[47:0] | {47'h0, |rem});
      end
   endfunction

   // Cycles an operation takes at this area setting
   function [4:0] latencyFor;
      input [3:0] op;
      begin
         case (op)
            `OP_FADD, `OP_FRSUB, `OP_FMUL, `OP_FINT: begin
               if (AREA_OPT == 1) latencyFor = `LAT_ARITH_1;
               else if (AREA_OPT == 2) latencyFor = `LAT_ARITH_2;
               else latencyFor = `LAT_ARITH_0;
            end
            `OP_FDIV: begin
               if (AREA_OPT == 1) latencyFor = `LAT_DIV_1;
               else if (AREA_OPT == 2) latencyFor = `LAT_DIV_2;
               else latencyFor = `LAT_DIV_0;
            end
            `OP_FCMP: begin
               if (AREA_OPT == 1) latencyFor = `LAT_CMP_1;
               else latencyFor = `LAT_CMP_0;
            end
            `OP_FLT: begin
               if (AREA_OPT == 1) latencyFor = `LAT_FLT_1;
               else if (AREA_OPT == 2) latencyFor = `LAT_FLT_2;
               else latencyFor = `LAT_FLT_0;
            end
            default: latencyFor = `LAT_ONE;
         endcase
      end
   endfunction

   // Operand classes
   wire zeroA, denA, infA, qnanA, snanA;
   wire zeroB, denB, infB, qnanB, snanB;
   float_classify #(.EXP_W(8), .FRAC_W(23)) classA (
      .value(operandA), .isZero(zeroA), .isDenorm(denA), .isInf(infA),
      .isQuietNan(qnanA), .isSigNan(snanA));
   float_classify #(.EXP_W(8), .FRAC_W(23)) classB (
      .value(operandB), .isZero(zeroB), .isDenorm(denB), .isInf(infB),
      .isQuietNan(qnanB), .isSigNan(snanB));

   // Registers
   reg [1:0] state_reg;          // Sequencer state
   reg [4:0] count_reg;          // Remaining cycles
   reg [31:0] pendResult_reg;    // Captured result
   reg [4:0] pendFlags_reg;      // Captured flags
   reg pendExc_reg;              // Captured exception
   reg pendWrite_reg;            // Captured write enable
   reg resultValid_reg;          // Completion pulse
   reg [31:0] resultData_reg;    // Result word
   reg resultWrite_reg;          // Destination write
   reg exceptionRaise_reg;       // Exception pulse
   reg [4:0] floatStatus_reg;    // Sticky flags
   reg [4:0] exceptionCause_reg; // Last cause
   reg busAck_reg;               // Bus answer phase
   reg [31:0] readData_reg;      // Bus read word

   // Combinational results
   reg [31:0] calcResult;
   reg [4:0] calcFlags;
   reg calcExc;
   reg calcWrite;
   reg [33:0] arith;
   reg [31:0] addX;
   reg [31:0] addY;
   reg cmpEq;
   reg cmpLess;
   reg cmpHit;
   reg [31:0] mag;
   reg [54:0] shifted;
   reg [31:0] intVal;

   // Integer compare pieces
   wire [31:0] intDiff;
   wire intGt;
   assign intDiff = operandB - operandA;
   assign intGt = unsignedSel ? (operandA > operandB) :
      ($signed(operandA) > $signed(operandB));
   wire accept;
   wire flagClear;
   assign accept = opStart & state_reg[0];
   assign flagClear = avs_write & busAck_reg &
      (avs_address == `REG_FLOAT_STATUS);

   // Operation result, flags and exception
   always @* begin
      calcResult = 32'h00000000;
      calcFlags = 5'h00;
      calcExc = 1'b0;
      calcWrite = 1'b1;
      arith = 34'h0;
      cmpEq = 1'b0;
      cmpLess = 1'b0;
      cmpHit = 1'b0;
      mag = 32'h00000000;
      shifted = 55'h0;
      intVal = 32'h00000000;
      addX = (opCode == `OP_FRSUB) ? operandB : operandA;
      addY = (opCode == `OP_FRSUB) ? {~operandA[31], operandA[30:0]} : operandB;
      case (opCode)
         `OP_INT_CMP: begin
            calcResult = {intGt, intDiff[30:0]};
         end
         `OP_FADD, `OP_FRSUB, `OP_FMUL, `OP_FDIV: begin
            if (!FPU_ON) begin
               calcWrite = 1'b0;
            end else if (denA | denB) begin
               calcResult = `DEFAULT_NAN;
               calcFlags[`FLAG_DO] = 1'b1;
               calcExc = 1'b1;
            end else if (snanA | snanB |
                  ((opCode == `OP_FADD || opCode == `OP_FRSUB) &&
                   infA && infB && (addX[31] != addY[31])) |
                  (opCode == `OP_FMUL && ((zeroA && infB) || (infA && zeroB))) |
                  (opCode == `OP_FDIV && ((zeroA && zeroB) || (infA && infB)))) begin
               calcResult = `DEFAULT_NAN;
               calcFlags[`FLAG_IO] = 1'b1;
               calcExc = 1'b1;
            end else if (qnanA | qnanB) begin
               calcResult = `DEFAULT_NAN;
            end else if (opCode == `OP_FMUL) begin
               // Infinity and zero pass through with product sign
               if (infA | infB) calcResult = {operandA[31] ^ operandB[31], 8'hFF, 23'h0};
               else if (zeroA | zeroB) calcResult = {operandA[31] ^ operandB[31], 31'h0};
               else arith = fpMul(operandA, operandB);
            end else if (opCode == `OP_FDIV) begin
               if (zeroA && !infB) begin
                  calcResult = {operandA[31] ^ operandB[31], 8'hFF, 23'h0};
                  calcFlags[`FLAG_DZ] = 1'b1;
                  calcExc = 1'b1;
               end else if (infB) calcResult = {operandA[31] ^ operandB[31], 8'hFF, 23'h0};
               else if (infA | zeroB) calcResult = {operandA[31] ^ operandB[31], 31'h0};
               else arith = fpDiv(operandB, operandA);
            end else begin
               // Single infinity dominates the sum
               if (infA | infB) calcResult = (infA ^ (opCode == `OP_FRSUB)) ? addX : addY;
               else arith = fpAdd(addX, addY);
            end
            if (FPU_ON && !(denA | denB | snanA | snanB | qnanA | qnanB | calcExc) &&
                  !((infA | infB | zeroA | zeroB) &&
                   (opCode == `OP_FMUL || opCode == `OP_FDIV)) &&
                  !((infA | infB) && opCode != `OP_FMUL && opCode != `OP_FDIV)) begin
               calcResult = arith[31:0];
               calcFlags[`FLAG_OF] = arith[33];
               calcFlags[`FLAG_UF] = arith[32];
               calcExc = arith[33] | arith[32];
            end
         end
         `OP_FCMP: begin
            // Ordered relation of B against A, zeros equal
            cmpEq = (operandA == operandB) || (zeroA && zeroB);
            if (zeroA && zeroB) cmpLess = 1'b0;
            else if (operandA[31] != operandB[31]) cmpLess = operandB[31];
            else if (!operandB[31]) cmpLess = operandB[30:0] < operandA[30:0];
            else cmpLess = operandB[30:0] > operandA[30:0];
            case (compareRelationSelect)
               `REL_LT: cmpHit = cmpLess;
               `REL_EQ: cmpHit = cmpEq;
               `REL_LE: cmpHit = cmpLess | cmpEq;
               `REL_GT: cmpHit = ~cmpLess & ~cmpEq;
               `REL_NE: cmpHit = ~cmpEq;
               `REL_GE: cmpHit = ~cmpLess;
               default: cmpHit = 1'b0;
            endcase
            if (!FPU_ON) begin
               calcWrite = 1'b0;
            end else if (denA | denB) begin
               calcFlags[`FLAG_DO] = 1'b1;
               calcExc = 1'b1;
            end else if (snanA | snanB | qnanA | qnanB) begin
               // Unordered: only un and ne are true
               calcResult = {31'h0, (compareRelationSelect == `REL_UN) ||
                  (compareRelationSelect == `REL_NE)};
               calcFlags[`FLAG_IO] = snanA | snanB |
                  (compareRelationSelect == `REL_LT) | (compareRelationSelect == `REL_LE) |
                  (compareRelationSelect == `REL_GT) | (compareRelationSelect == `REL_GE);
               calcExc = calcFlags[`FLAG_IO];
            end else begin
               calcResult = {31'h0, cmpHit};
            end
         end
         `OP_FLT: begin
            mag = operandA[31] ? (~operandA + 32'h00000001) : operandA;
            arith = roundPack(operandA[31], `I2F_EXP, {mag, 16'h0000});
            calcResult = arith[31:0];
            calcWrite = FPU_EXT;
         end
         `OP_FINT: begin
            shifted = {31'h0, 1'b1, operandA[22:0]} << (operandA[30:23] - 8'h7F);
            intVal = (operandA[30:23] < 8'h7F) ? 32'h00000000 : shifted[54:23];
            if (!FPU_EXT) begin
               calcWrite = 1'b0;
            end else if (denA) begin
               calcResult = `DEFAULT_NAN;
               calcFlags[`FLAG_DO] = 1'b1;
               calcExc = 1'b1;
            end else if (qnanA | snanA | infA | (operandA[30:23] > `F2I_EXP_LIMIT) |
                  ((operandA[30:23] == `F2I_EXP_LIMIT) &&
                   (!operandA[31] || (|operandA[22:0])))) begin
               calcResult = `DEFAULT_NAN;
               calcFlags[`FLAG_IO] = 1'b1;
               calcExc = 1'b1;
            end else begin
               calcResult = operandA[31] ? (~intVal + 32'h00000001) : intVal;
            end
         end
         default: begin
            calcWrite = 1'b0;
         end
      endcase
      // Exception suppresses the destination write
      if (calcExc) calcWrite = 1'b0;
   end

   // Sequencer, latency count and result capture
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         count_reg <= 5'h00;
         pendResult_reg <= 32'h00000000;
         pendFlags_reg <= 5'h00;
         pendExc_reg <= 1'b0;
         pendWrite_reg <= 1'b0;
         resultValid_reg <= 1'b0;
         resultData_reg <= 32'h00000000;
         resultWrite_reg <= 1'b0;
         exceptionRaise_reg <= 1'b0;
      end else begin
         resultValid_reg <= 1'b0;
         resultWrite_reg <= 1'b0;
         exceptionRaise_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // Take a new operation and its results
               if (accept) begin
                  state_reg <= ST_RUN;
                  count_reg <= latencyFor(opCode) - 5'h01;
                  pendResult_reg <= calcResult;
                  pendFlags_reg <= calcFlags;
                  pendExc_reg <= calcExc;
                  pendWrite_reg <= calcWrite;
               end
            end
            ST_RUN: begin
               // Release after the documented latency
               if (count_reg == 5'h00) begin
                  state_reg <= ST_IDLE;
                  resultValid_reg <= 1'b1;
                  resultData_reg <= pendResult_reg;
                  resultWrite_reg <= pendWrite_reg;
                  exceptionRaise_reg <= pendExc_reg;
               end else begin
                  count_reg <= count_reg - 5'h01;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Sticky status flags and exception cause
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         floatStatus_reg <= 5'h00;
         exceptionCause_reg <= `CAUSE_NONE;
      end else begin
         // Set wins over a software clear in the same cycle
         if (flagClear) begin
            floatStatus_reg <= (floatStatus_reg & ~avs_writedata[`FLAG_W-1:0]) |
               ((state_reg[1] && count_reg == 5'h00) ? pendFlags_reg : 5'h00);
         end else if (state_reg[1] && count_reg == 5'h00) begin
            floatStatus_reg <= floatStatus_reg | pendFlags_reg;
         end
         if (state_reg[1] && count_reg == 5'h00 && pendExc_reg) begin
            exceptionCause_reg <= `CAUSE_FP;
         end
      end
   end

   // Avalon slave: one wait cycle, then the answer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         busAck_reg <= 1'b0;
         readData_reg <= 32'h00000000;
      end else begin
         if ((avs_read | avs_write) && !busAck_reg) begin
            busAck_reg <= 1'b1;
            if (avs_address == `REG_FLOAT_STATUS) begin
               readData_reg <= {27'h0, floatStatus_reg};
            end else if (avs_address == `REG_EXC_CAUSE) begin
               readData_reg <= {27'h0, exceptionCause_reg};
            end else if (avs_address == `REG_UNIT_INFO) begin
               readData_reg <= {28'h0, AREA_CODE, CONFIG_CODE};
            end else begin
               readData_reg <= 32'h00000000;
            end
         end else begin
            busAck_reg <= 1'b0;
         end
      end
   end

   // Output drive
   assign opReady = state_reg[0];
   assign resultValid = resultValid_reg;
   assign resultData = resultData_reg;
   assign resultWrite = resultWrite_reg;
   assign exceptionRaise = exceptionRaise_reg;
   assign exceptionCauseCode = exceptionCause_reg;
   assign avs_readdata = readData_reg;
   assign avs_waitrequest = (avs_read | avs_write) & ~busAck_reg;
endmodule
`default_nettype wire

/* test/float_unit_chk.sv */
// Port checker for the float unit and integer compare
`timescale 1ns/10ps
`default_nettype none
module float_unit_chk #(
   parameter AREA_OPT = 0
) (
   // Clock, reset and issue side
   input wire logic clk, rst, opStart, unsignedSel, opReady,
   input wire logic [3:0] opCode,
   input wire logic [31:0] operandA, operandB,
   // Result side
   input wire logic resultValid, resultWrite, exceptionRaise,
   input wire logic [31:0] resultData,
   input wire logic [4:0] exceptionCauseCode
);
   // Latency plus the sampling edge
   localparam int LA1 = (AREA_OPT == 0) ? 5 : (AREA_OPT == 1) ? 7 : 2;
   localparam int LD1 = (AREA_OPT == 0) ? 29 : (AREA_OPT == 1) ? 31 : 25;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Request taken at this edge
   wire logic acc = opStart && opReady;
   icmp_done_a: assert property (acc && opCode == 4'h0 |-> ##2 resultValid && resultWrite)
      else $error("int compare late");
   icmp_diff_a: assert property (acc && opCode == 4'h0 |->
      ##2 resultData[30:0] == 31'($past(operandB, 2) - $past(operandA, 2))) else $error("diff");
   icmp_msb_a: assert property (acc && opCode == 4'h0 |-> ##2 resultData[31] ==
      ($past(unsignedSel, 2) ? $past(operandA, 2) > $past(operandB, 2) :
      $signed($past(operandA, 2)) > $signed($past(operandB, 2)))) else $error("sign bit");
   arith_lat_a: assert property (acc && opCode inside {4'h1, 4'h2, 4'h3, 4'h7} |->
      ##LA1 resultValid) else $error("arith latency");
   div_busy_a: assert property (acc && opCode == 4'h4 |=> !opReady [*8])
      else $error("divide not busy");
   div_lat_a: assert property (acc && opCode == 4'h4 |-> ##LD1 resultValid)
      else $error("divide latency");
   exc_keep_a: assert property (exceptionRaise |-> resultValid && !resultWrite &&
      exceptionCauseCode == 5'h06) else $error("exception wrote result");
   cause_stick_a: assert property (exceptionCauseCode == 5'h06 |=>
      exceptionCauseCode == 5'h06) else $error("cause lost");
endmodule
bind float_unit_and_int_compare float_unit_chk #(.AREA_OPT(AREA_OPT)) float_unit_chk_inst (.*);
`default_nettype wire

/* test/issue_model.sv */
// Issue stage model presenting operations to the float unit
`timescale 1ns/10ps
`default_nettype none
module issue_model (
   // Clock and handshake
   input wire logic clk, opReady,
   // Request fields, idle at time zero
   output logic opStart = 1'b0,
   output logic unsignedSel = 1'b0,
   output logic [3:0] opCode = 4'h0,
   output logic [2:0] compareRelationSelect = 3'h0,
   output logic [31:0] operandA = 32'h0,
   output logic [31:0] operandB = 32'h0
);
   // Hold a request until taken, then scramble the released operands
   task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
         input logic [3:0] x);
      @(posedge clk);
      opStart <= 1'b1;
      opCode <= op;
      operandA <= a;
      operandB <= b;
      {unsignedSel, compareRelationSelect} <= x;
      do @(posedge clk); while (opReady !== 1'b1);
      opStart <= 1'b0;
      operandA <= ~a;
      operandB <= ~b;
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Bench for the float unit and integer compare
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [31:0] fOne = 32'h3F800000, fTwo = 32'h40000000;
   localparam logic [31:0] fInf = 32'h7F800000, dNan = 32'hFFC00000;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [1:0] avs_address = 2'h0;
   logic [31:0] avs_writedata = 32'h0;
   wire logic [31:0] avs_readdata, resultData, operandA, operandB;
   wire logic [4:0] exceptionCauseCode;
   wire logic [3:0] opCode;
   wire logic [2:0] compareRelationSelect;
   wire logic opStart, unsignedSel, opReady, resultValid, resultWrite, exceptionRaise;
   wire logic avs_waitrequest;
   int error_cnt = 0;
   int compares = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   float_unit_and_int_compare #(.AREA_OPT(2), .FLOAT_UNIT_CONFIG(2))
      float_unit_and_int_compare_inst (.*);
   issue_model issue_model_inst (.*);
   // Count one comparison, report a mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Counts, verdict, end of run
   task automatic report_and_stop;
      $display("error_cnt=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One bus access held until waitrequest low; a read is judged
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!w) chk(avs_readdata, d);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Issue one operation and judge data, write and exception
   task automatic run(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
         input logic [31:0] d, input logic w, input logic [3:0] x = 4'h0);
      issue_model_inst.issue(op, a, b, x);
      do @(posedge clk); while (resultValid !== 1'b1);
      chk(resultData, d);
      chk(32'({resultWrite, exceptionRaise}), 32'({w, !w}));
   endtask
   // Plain integer, conversion and arithmetic results
   task automatic t_basic;
      run(4'h0, 32'h1, 32'hFFFFFFFF, 32'hFFFFFFFE, 1'b1);
      run(4'h0, 32'h1, 32'hFFFFFFFF, 32'h7FFFFFFE, 1'b1, 4'h8);
      run(4'h6, 32'hFFFFFFFE, 32'h0, 32'hC0000000, 1'b1);
      run(4'h7, 32'hC0600000, 32'h0, 32'hFFFFFFFD, 1'b1);
      run(4'h7, 32'h4F000000, 32'h0, dNan, 1'b0);
      run(4'h1, fOne, fTwo, 32'h40400000, 1'b1);
      run(4'h2, fOne, 32'h40400000, fTwo, 1'b1);
      run(4'h3, fTwo, 32'h40400000, 32'h40C00000, 1'b1);
      run(4'h4, fTwo, 32'h40C00000, 32'h40400000, 1'b1);
   endtask
   // Special operands and out-of-range results
   task automatic t_special;
      run(4'h1, 32'h1, fOne, dNan, 1'b0);
      run(4'h1, fInf, 32'hFF800000, dNan, 1'b0);
      run(4'h2, fInf, fInf, dNan, 1'b0);
      run(4'h2, fInf, fOne, 32'hFF800000, 1'b1);
      run(4'h3, 32'h0, fInf, dNan, 1'b0);
      run(4'h4, 32'h0, 32'h0, dNan, 1'b0);
      run(4'h1, 32'h7FC00000, fOne, dNan, 1'b1);
      run(4'h4, 32'h0, 32'hBF800000, 32'hFF800000, 1'b0);
      run(4'h3, 32'h7F000000, 32'h7F000000, fInf, 1'b0);
      run(4'h3, 32'h00800000, 32'h00800000, 32'h0, 1'b0);
   endtask
   // Every relation, ordered and with a quiet NaN
   task automatic t_fcmp;
      for (int r = 0; r < 7; r++) begin
         run(4'h5, fOne, fTwo, 32'(r > 3), 1'b1, 4'(r));
         run(4'h5, fOne, 32'h7FC00000, 32'(r % 5 == 0), r inside {0,2,5}, 4'(r));
      end
   endtask
   // Sticky flags, read-only cause, info and unmapped word
   task automatic t_regs;
      bus(1'b0, 2'h0, 32'h0000001F);
      bus(1'b1, 2'h0, 32'h0000001F);
      run(4'h1, fOne, fOne, fTwo, 1'b1);
      bus(1'b0, 2'h0, 32'h0);
      bus(1'b1, 2'h1, 32'h0);
      bus(1'b0, 2'h1, 32'h00000006);
      bus(1'b0, 2'h2, 32'h0000000A);
      bus(1'b1, 2'h3, 32'h0000FFFF);
      bus(1'b0, 2'h3, 32'h0);
   endtask
   // Reset, scenarios, verdict
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_basic;
      t_special;
      t_fcmp;
      t_regs;
      report_and_stop;
   end
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      report_and_stop;
   end
endmodule
`default_nettype wire
